// >>> design/pad_acceptance.sv
`default_nettype none
// How it works
// - Thirty-two analog channels, each with its own peak hold stage.
// - Channels pass four-way multiplexers into one shared converter.
// - Twelve-bit results; a full scan of all channels ends within 10 us unless a stalled buffer fills the FIFO.
// - Charge during window, convert after it closes, then pulse discharge.
// - With sliding scale on, added level is subtracted before threshold test.
// - With sliding scale on, only results up to 3840 are valid.
// - Value at or above the channel threshold goes to the buffer.
// - Compare top eight result bits with the 8-bit threshold.
// - Below-threshold value kept only when keep-below select is 1.
// - Kept below-threshold word has bit 13 set.
// - One threshold entry per channel, undefined until written.
// - Discard bit blocks storing the channel even above threshold.
// - Threshold entries survive every reset.
// - By default an overflowed result is not stored.
// - Keep-saturated select stores overflows, marking bit 12.
// - Only values passing all tests or admitted by overrides reach buffer.
// - Discard bit 1 aborts storing; 0 lets normal tests run.
// - Word holds result in bits 11..0, channel in bits 21..16.
module pad_acceptance #(
  parameter int N_CH       = pad_pkg::N_CH,
  parameter int FIFO_DEPTH = pad_pkg::FIFO_DEPTH
) (
  input  wire logic                   sys_clk,
  input  wire logic                   arst_n,
  input  wire logic                   gate_in,
  input  wire logic                   keep_below_level_select,
  input  wire logic                   keep_saturated_select,
  input  wire logic                   slide_enable,
  output logic                        charge_switch,
  output logic                        discharge_switch,
  output logic [1:0]                  mux_way_sel,
  output logic [N_CH/4-1:0]           mux_bank_en,
  output logic                        adc_start,
  input  wire logic [11:0]            adc_data,
  input  wire logic                   adc_ovf,
  output logic [7:0]                  slide_dac,
  input  wire logic [15:0]            host_addr,
  input  wire logic                   host_wr,
  input  wire logic                   host_rd,
  input  wire logic [15:0]            host_wdata,
  output logic [15:0]                 host_rdata,
  output logic                        host_ack,
  output logic                        buf_wr_valid,
  input  wire logic                   buf_wr_ready,
  output logic [pad_pkg::WORD_W-1:0]  buf_wr_data,
  output logic                        busy
);
  localparam int CH_W       = $clog2(N_CH);
  localparam int CONV_BOUND = pad_pkg::CONV_ALL_CYC;
  localparam int CLR_M1     = pad_pkg::CLEAR_CYC - 1;
  localparam int CONV_LEN   = pad_pkg::CONV_CH_CYC;

  generate
    if (N_CH < 8 || N_CH > 64 || (N_CH % pad_pkg::MUX_WAYS) != 0) begin : g_chk
      $error("pad_acceptance channel count unsupported");
    end
  endgenerate

  // Reset release
  logic rst_s1_reg;
  logic rst_n_reg;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  // Gate pin synchroniser
  logic g1_reg;
  logic g2_reg;
  logic g3_reg;
  logic gate_lvl_reg;
  logic gate_prev_reg;
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      g1_reg        <= 1'b0;
      g2_reg        <= 1'b0;
      g3_reg        <= 1'b0;
      gate_lvl_reg  <= 1'b0;
      gate_prev_reg <= 1'b0;
    end else begin
      g1_reg        <= gate_in;
      g2_reg        <= g1_reg;
      g3_reg        <= g2_reg;
      gate_prev_reg <= gate_lvl_reg;
      if (g2_reg == g3_reg) begin
        gate_lvl_reg <= g3_reg;
      end
    end
  end

  // Sequencer
  pad_pkg::pad_state_t state_reg;
  logic [pad_pkg::TMR_W-1:0] timer_reg;
  logic [CH_W-1:0]           chan_reg;
  logic                      accept;
  logic                      fifo_in_ready;
  logic                      stall;
  logic                      last_conv;
  logic                      last_clear;
  assign stall      = (state_reg == pad_pkg::ST_STORE) && accept && !fifo_in_ready;
  assign last_conv  = timer_reg == pad_pkg::TMR_W'(CONV_LEN - 1);
  assign last_clear = timer_reg == pad_pkg::TMR_W'(CLR_M1);

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= pad_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        pad_pkg::ST_IDLE: begin
          if (gate_lvl_reg && !gate_prev_reg) begin
            state_reg <= pad_pkg::ST_SAMPLE;
          end
        end
        pad_pkg::ST_SAMPLE: begin
          if (!gate_lvl_reg) begin
            state_reg <= pad_pkg::ST_CONV;
          end
        end
        pad_pkg::ST_CONV: begin
          if (last_conv) begin
            state_reg <= pad_pkg::ST_STORE;
          end
        end
        pad_pkg::ST_STORE: begin
          if (!stall) begin
            if (chan_reg == CH_W'(N_CH - 1)) begin
              state_reg <= pad_pkg::ST_CLEAR;
            end else begin
              state_reg <= pad_pkg::ST_CONV;
            end
          end
        end
        pad_pkg::ST_CLEAR: begin
          if (last_clear) begin
            state_reg <= pad_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      timer_reg <= '0;
    end else if (state_reg == pad_pkg::ST_CONV && !last_conv) begin
      timer_reg <= timer_reg + 1'b1;
    end else if (state_reg == pad_pkg::ST_CLEAR && !last_clear) begin
      timer_reg <= timer_reg + 1'b1;
    end else begin
      timer_reg <= '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      chan_reg <= '0;
    end else if (state_reg == pad_pkg::ST_SAMPLE) begin
      chan_reg <= '0;
    end else if (state_reg == pad_pkg::ST_STORE && !stall) begin
      chan_reg <= chan_reg + 1'b1;
    end
  end

  assign charge_switch    = state_reg == pad_pkg::ST_SAMPLE;
  assign discharge_switch = state_reg == pad_pkg::ST_CLEAR;
  assign adc_start = (state_reg == pad_pkg::ST_CONV) && (timer_reg == '0);
  assign busy      = state_reg != pad_pkg::ST_IDLE;
  assign mux_way_sel = chan_reg[1:0];

  genvar gb;
  generate
    for (gb = 0; gb < N_CH / 4; gb++) begin : g_bank
      assign mux_bank_en[gb] = (state_reg == pad_pkg::ST_CONV)
                               && (chan_reg[CH_W-1:2] == (CH_W - 2)'(gb));
    end
  endgenerate

  // Sliding scale level, stepped once per conversion
  logic [7:0] slide_reg;
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      slide_reg <= pad_pkg::SLIDE_RST;
    end else if (!slide_enable) begin
      slide_reg <= pad_pkg::SLIDE_RST;
    end else if (state_reg == pad_pkg::ST_STORE && !stall) begin
      slide_reg <= slide_reg + 1'b1;
    end
  end
  assign slide_dac = slide_reg;

  // Converter result capture at end of conversion
  logic [11:0] raw_reg;
  logic        ovf_in_reg;
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      raw_reg    <= '0;
      ovf_in_reg <= 1'b0;
    end else if (state_reg == pad_pkg::ST_CONV && last_conv) begin
      raw_reg    <= adc_data;
      ovf_in_reg <= adc_ovf;
    end
  end

  // Threshold table
  logic [CH_W-1:0]              host_idx;
  logic                         host_hit;
  logic [15:0]                  host_off;
  logic [pad_pkg::THR_ENT_W-1:0] host_ent;
  logic [pad_pkg::THR_ENT_W-1:0] look_ent;
  assign host_off = host_addr - pad_pkg::THR_BASE;
  assign host_idx = host_off[CH_W:1];
  assign host_hit = (host_addr >= pad_pkg::THR_BASE) && (host_addr <= pad_pkg::THR_LAST)
                    && !host_addr[0];

  pad_thr_table #(
    .N  (N_CH),
    .EW (pad_pkg::THR_ENT_W)
  ) u_thr (
    .sys_clk    (sys_clk),
    .host_idx   (host_idx),
    .host_wr    (host_wr && host_hit),
    .host_wdata (host_wdata[pad_pkg::THR_ENT_W-1:0]),
    .host_rdata (host_ent),
    .look_idx   (chan_reg),
    .look_data  (look_ent)
  );

  logic hit_rd_reg;
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      host_ack   <= 1'b0;
      hit_rd_reg <= 1'b0;
    end else begin
      host_ack   <= host_wr || host_rd;
      hit_rd_reg <= host_rd && host_hit;
    end
  end
  assign host_rdata = hit_rd_reg ? {7'h00, host_ent} : 16'h0000;

  // Acceptance decision
  logic [11:0] corr;
  logic [7:0]  thr_val;
  logic        kill;
  logic        ovf;
  logic        ge;
  logic [pad_pkg::WORD_W-1:0] word;
  assign corr    = (raw_reg >= {4'h0, slide_reg}) ? raw_reg - {4'h0, slide_reg} : 12'h000;
  assign thr_val = look_ent[pad_pkg::THR_VAL_LSB +: pad_pkg::THR_W];
  assign kill    = look_ent[pad_pkg::THR_KILL_BIT];
  assign ovf     = ovf_in_reg || (raw_reg == pad_pkg::ADC_FULL)
                   || (slide_enable && corr > pad_pkg::SLIDE_MAX);
  assign ge      = corr[11:4] >= thr_val;
  assign accept  = !kill && (ge || keep_below_level_select)
                   && (!ovf || keep_saturated_select);

  always_comb begin
    word = '0;
    word[pad_pkg::W_DATA_LSB +: pad_pkg::ADC_W] = corr;
    word[pad_pkg::W_OVF_BIT]   = ovf;
    word[pad_pkg::W_BELOW_BIT] = !ge;
    word[pad_pkg::W_CH_LSB +: pad_pkg::W_CH_W] = pad_pkg::W_CH_W'(chan_reg);
  end

  logic push;
  assign push = (state_reg == pad_pkg::ST_STORE) && accept;

  pad_fifo #(
    .W     (pad_pkg::WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n_reg),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (word),
    .out_valid (buf_wr_valid),
    .out_ready (buf_wr_ready),
    .out_data  (buf_wr_data)
  );

  a_switch_excl: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    !(charge_switch && discharge_switch)) else $error("charge and discharge together");
  a_clear_after: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    $rose(discharge_switch) |-> $past(state_reg) == pad_pkg::ST_STORE
    && $past(chan_reg) == CH_W'(N_CH - 1)) else $error("discharge before scan end");
  a_clear_len: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    $rose(discharge_switch) |-> ##CLR_M1 discharge_switch ##1 !discharge_switch)
    else $error("discharge pulse length wrong");

  // Scan time since the window closed, stalled store cycles left out
  logic [11:0] scan_cyc_reg;
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      scan_cyc_reg <= '0;
    end else if (state_reg == pad_pkg::ST_SAMPLE) begin
      scan_cyc_reg <= '0;
    end else if (state_reg inside {pad_pkg::ST_CONV, pad_pkg::ST_STORE} && !stall) begin
      scan_cyc_reg <= scan_cyc_reg + 1'b1;
    end
  end
  a_scan_budget: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    (state_reg == pad_pkg::ST_CONV || state_reg == pad_pkg::ST_STORE)
    |-> scan_cyc_reg < 12'(CONV_BOUND)) else $error("scan exceeded budget");
  a_thr_pass: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    push && !word[pad_pkg::W_BELOW_BIT] |-> corr[11:4] >= thr_val)
    else $error("below flag clear under threshold");
  a_keep_below: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    push && word[pad_pkg::W_BELOW_BIT] |-> keep_below_level_select)
    else $error("below value stored without select");
  a_keep_sat: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    push && word[pad_pkg::W_OVF_BIT] |-> keep_saturated_select)
    else $error("overflow stored without select");
  a_kill_block: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    (state_reg == pad_pkg::ST_STORE) && kill |-> !push) else $error("killed channel stored");
  a_slide_range: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    push && slide_enable && !word[pad_pkg::W_OVF_BIT] |-> corr <= pad_pkg::SLIDE_MAX)
    else $error("slide result over range not flagged");
  a_chan_field: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    push |-> word[pad_pkg::W_CH_LSB +: pad_pkg::W_CH_W] == pad_pkg::W_CH_W'(chan_reg))
    else $error("channel field wrong");
  a_one_strobe: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    push && fifo_in_ready |=> !push) else $error("two pushes for one channel");
  a_ack_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    (host_wr || host_rd) |=> host_ack) else $error("host access not acknowledged");
  a_drop_below: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    (state_reg == pad_pkg::ST_STORE) && (corr[11:4] < thr_val) && !keep_below_level_select
    |-> !push) else $error("below value stored without select");
  a_ovf_drop: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    (state_reg == pad_pkg::ST_STORE) && ovf_in_reg && !keep_saturated_select
    |-> !push) else $error("overflowed value stored");
  a_pass_store: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    (state_reg == pad_pkg::ST_STORE) && !kill && (corr[11:4] >= thr_val) && !ovf
    |-> push) else $error("passing value not stored");
endmodule : pad_acceptance
`default_nettype wire

// >>> design/pad_fifo.sv
`default_nettype none
module pad_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("pad_fifo depth must be a power of two");
    end
  endgenerate
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr_reg;
  logic [AW:0]  rd_ptr_reg;
  logic         full;
  logic         empty;
  assign empty     = wr_ptr_reg == rd_ptr_reg;
  assign full      = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) && !empty;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];
  always_ff @(posedge sys_clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
    end else if (in_valid && !full) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_reg <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
  a_fifo_no_over: assert property (@(posedge sys_clk) disable iff (!rst_n)
    full |-> !in_ready ##1 $stable(wr_ptr_reg)) else $error("fifo written while full");
endmodule : pad_fifo
`default_nettype wire

// >>> design/pad_pkg.sv
`default_nettype none
package pad_pkg;
  localparam int          N_CH        = 32;
  localparam int          MUX_WAYS    = 4;
  localparam int          ADC_W       = 12;
  localparam int          THR_W       = 8;
  localparam int          WORD_W      = 32;
  localparam int          FIFO_DEPTH  = 16;
  localparam int          CLK_MHZ     = 250;
  // Whole scan of all channels, longest time, rounded down
  localparam int          CONV_ALL_NS = 10000;
  localparam int          CONV_ALL_CYC = CONV_ALL_NS * CLK_MHZ / 1000;
  // One cycle per channel goes to the store step
  localparam int          CONV_CH_CYC = CONV_ALL_CYC / N_CH - 1;
  // Discharge pulse, least time, rounded up
  localparam int          CLEAR_NS    = 500;
  localparam int          CLEAR_CYC   = (CLEAR_NS * CLK_MHZ + 999) / 1000;
  localparam int          TMR_W       = 8;
  localparam logic [15:0] THR_BASE    = 16'h1080;
  localparam logic [15:0] THR_LAST    = 16'h10BE;
  localparam int          THR_VAL_LSB = 0;
  localparam int          THR_KILL_BIT = 8;
  localparam int          THR_ENT_W   = 9;
  localparam logic [11:0] SLIDE_MAX   = 12'hF00;
  localparam logic [11:0] ADC_FULL    = 12'hFFF;
  localparam logic [7:0]  SLIDE_RST   = 8'h00;
  localparam int          W_DATA_LSB  = 0;
  localparam int          W_OVF_BIT   = 12;
  localparam int          W_BELOW_BIT = 13;
  localparam int          W_CH_LSB    = 16;
  localparam int          W_CH_W      = 6;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONV,
    ST_STORE,
    ST_CLEAR
  } pad_state_t;
endpackage : pad_pkg
`default_nettype wire

// >>> design/pad_thr_table.sv
`default_nettype none
module pad_thr_table #(
  parameter int N  = 32,
  parameter int EW = 9
) (
  input  wire logic                 sys_clk,
  input  wire logic [$clog2(N)-1:0] host_idx,
  input  wire logic                 host_wr,
  input  wire logic [EW-1:0]        host_wdata,
  output logic      [EW-1:0]        host_rdata,
  input  wire logic [$clog2(N)-1:0] look_idx,
  output logic      [EW-1:0]        look_data
);
  generate
    if (N < 2 || EW < 1) begin : g_chk
      $error("pad_thr_table size out of range");
    end
  endgenerate
  // No reset: contents survive any reset, undefined until written
  logic [EW-1:0] mem [N];
  always_ff @(posedge sys_clk) begin
    if (host_wr) begin
      mem[host_idx] <= host_wdata;
    end
    host_rdata <= mem[host_idx];
  end
  assign look_data = mem[look_idx];
  a_tbl_write: assert property (@(posedge sys_clk)
    host_wr |=> mem[$past(host_idx)] == $past(host_wdata)) else $error("table write lost");
endmodule : pad_thr_table
`default_nettype wire

// >>> testbench/pad_acceptance_test.sv
`default_nettype none
module pad_acceptance_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic kb; logic ks; logic sl; logic slow;} pad_row_t;
  logic        sys_clk    = 1'h0;
  logic        arst_n     = 1'h0;
  logic        gate_in    = 1'h0;
  logic        kb         = 1'h0;
  logic        ks         = 1'h0;
  logic        sl         = 1'h0;
  logic        stall      = 1'h0;
  logic        slow       = 1'h0;
  logic [11:0] adc_data   = 12'h000;
  logic        adc_ovf    = 1'h0;
  logic [15:0] host_addr  = 16'h0000;
  logic        host_wr    = 1'h0;
  logic        host_rd    = 1'h0;
  logic [15:0] host_wdata = 16'h0000;
  logic        charge_switch, discharge_switch, adc_start, host_ack, busy;
  logic        buf_wr_valid, buf_wr_ready;
  logic [1:0]  mux_way_sel;
  logic [7:0]  mux_bank_en, slide_dac;
  logic [15:0] host_rdata;
  logic [31:0] buf_wr_data;
  logic [31:0] exp_q[$];
  int          fails = 0;
  int          n_checks = 0;
  int          starts = 0;
  int          conv_cyc = 0;
  pad_row_t    rows [4] = '{'{1'h0, 1'h0, 1'h0, 1'h0}, '{1'h1, 1'h0, 1'h0, 1'h1},
                            '{1'h0, 1'h1, 1'h0, 1'h0}, '{1'h1, 1'h0, 1'h1, 1'h0}};

  pad_acceptance pad_acceptance_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .gate_in(gate_in),
    .keep_below_level_select(kb), .keep_saturated_select(ks), .slide_enable(sl),
    .charge_switch(charge_switch), .discharge_switch(discharge_switch),
    .mux_way_sel(mux_way_sel), .mux_bank_en(mux_bank_en), .adc_start(adc_start),
    .adc_data(adc_data), .adc_ovf(adc_ovf), .slide_dac(slide_dac),
    .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_ack(host_ack),
    .buf_wr_valid(buf_wr_valid), .buf_wr_ready(buf_wr_ready),
    .buf_wr_data(buf_wr_data), .busy(busy)
  );
  pad_buf_sink pad_buf_sink_inst (
    .sys_clk(sys_clk), .wr_valid(buf_wr_valid), .wr_data(buf_wr_data),
    .stall(stall), .slow(slow), .wr_ready(buf_wr_ready)
  );

  always #2 sys_clk = ~sys_clk;

  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [7:0] thr_of(int ch);
    return (ch == 7) ? 8'hFF : 8'(ch * 4 + 2);
  endfunction : thr_of

  // Values just below, at and above each threshold, plus range edges
  function automatic logic [11:0] val_of(int ch, logic s);
    if (ch == 31) return 12'hFFF;
    if (s && ch == 30) return 12'hF01;
    if (s && ch == 29) return 12'hF00;
    return {8'(thr_of(ch) + ch % 3 - 1), 4'(ch)};
  endfunction : val_of

  // Analog side: adds the sliding level, saturates, scrambles when unselected
  always @(posedge sys_clk) begin
    int          c;
    logic [12:0] sum;
    #1;
    c = -1;
    for (int b = 0; b < 8; b++) if (mux_bank_en[b] === 1'h1) c = b * 4 + mux_way_sel;
    if (c < 0) begin
      adc_data = ~adc_data;
    end else begin
      sum = {1'h0, val_of(c, sl)} + (sl ? {5'h00, slide_dac} : 13'h0000);
      adc_data = sum[12] ? 12'hFFF : sum[11:0];
      adc_ovf = (c == 5);
    end
  end

  always @(posedge sys_clk) begin
    if (adc_start === 1'h1) begin
      chk("charge_at_start", 32'h0, {31'h0, charge_switch});
      chk("mux_bank", 32'(1 << (starts / 4)), {24'h0, mux_bank_en});
      chk("mux_way", 32'(starts % 4), {30'h0, mux_way_sel});
      starts++;
    end
    if (discharge_switch === 1'h1 && starts != 32) chk("discharge_early", 32, starts);
    if (busy === 1'h1 && !charge_switch && !discharge_switch && starts > 0) conv_cyc++;
  end

  task automatic build_exp();
    logic [11:0] v;
    logic        ov;
    logic        bl;
    exp_q.delete();
    for (int ch = 0; ch < 32; ch++) begin
      v  = val_of(ch, sl);
      ov = (ch == 5) || (v == 12'hFFF) || (sl && v > 12'hF00);
      bl = v[11:4] < thr_of(ch);
      if (ch != 7 && (!ov || ks) && (!bl || kb))
        exp_q.push_back({10'h000, 6'(ch), 2'h0, bl, ov, v});
    end
  endtask : build_exp

  task automatic host_op(input logic wr, input logic [15:0] a, input logic [15:0] d,
                         input logic [15:0] exp_rd);
    @(posedge sys_clk) #1;
    host_addr = a;
    host_wdata = d;
    host_wr = wr;
    host_rd = !wr;
    @(posedge sys_clk) #1;
    host_wr = 1'h0;
    host_rd = 1'h0;
    chk("host_ack", 32'h1, {31'h0, host_ack});
    if (!wr) chk("host_rdata", {16'h0, exp_rd}, {16'h0, host_rdata});
  endtask : host_op

  task automatic do_reset();
    @(posedge sys_clk) #1;
    arst_n = 1'h0;
    repeat (20) @(posedge sys_clk);
    #1;
    chk("reset_outs", 32'h0, {27'h0, busy, charge_switch, discharge_switch,
        buf_wr_valid, host_ack});
    pad_buf_sink_inst.got.delete();
    arst_n = 1'h1;
    repeat (5) @(posedge sys_clk);
  endtask : do_reset

  task automatic pulse_gate();
    starts = 0;
    conv_cyc = 0;
    @(posedge sys_clk) #1;
    gate_in = 1'h1;
    repeat (10) @(posedge sys_clk);
    #1;
    chk("charge_switch", 32'h1, {31'h0, charge_switch});
    gate_in = 1'h0;
  endtask : pulse_gate

  task automatic finish_scan(input logic timed);
    int k;
    k = 0;
    while (busy !== 1'h0 && k < 8000) begin
      @(posedge sys_clk);
      k++;
    end
    k = 0;
    while (buf_wr_valid !== 1'h0 && k < 200) begin
      @(posedge sys_clk);
      k++;
    end
    repeat (4) @(posedge sys_clk);
    #1;
    chk("busy_end", 32'h0, {31'h0, busy});
    chk("adc_starts", 32'd32, 32'(starts));
    if (timed) chk("conv_in_time", 32'h1, 32'(conv_cyc <= 2500));
    build_exp();
    chk("word_count", 32'(exp_q.size()), 32'(pad_buf_sink_inst.got.size()));
    foreach (exp_q[i]) chk("buf_word", exp_q[i], pad_buf_sink_inst.got[i]);
    pad_buf_sink_inst.got.delete();
  endtask : finish_scan

  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    close_out();
  end

  initial begin
    do_reset();
    for (int ch = 0; ch < 32; ch++)
      host_op(1'h1, 16'h1080 + 16'(2 * ch), {7'h00, 1'(ch == 7), thr_of(ch)}, 16'h0);
    host_op(1'h1, 16'h108E, 16'hFFFF, 16'h0000);
    host_op(0, 16'h108E, 16'h0000, 16'h01FF);
    host_op(1'h1, 16'h1083, 16'h0000, 16'h0000);
    host_op(0, 16'h1082, 16'h0000, {8'h00, thr_of(1)});
    host_op(0, 16'h1000, 16'h0000, 16'h0000);
    foreach (rows[i]) begin
      {kb, ks, sl, slow} = rows[i];
      pulse_gate();
      finish_scan(1'h1);
    end
    stall = 1'h1;
    pulse_gate();
    repeat (3000) @(posedge sys_clk);
    #1;
    chk("busy_stalled", 32'h1, {31'h0, busy});
    chk("words_held", 32'h0, 32'(pad_buf_sink_inst.got.size()));
    stall = 1'h0;
    finish_scan(1'h0);
    {kb, ks, sl, slow} = rows[0];
    pulse_gate();
    repeat (500) @(posedge sys_clk);
    do_reset();
    pulse_gate();
    finish_scan(1'h1);
    close_out();
  end
endmodule : pad_acceptance_test
`default_nettype wire

// >>> testbench/pad_buf_sink.sv
`default_nettype none
// Dual-port buffer write side: takes words, can stall or accept every other cycle
module pad_buf_sink (
  input  wire logic                         sys_clk,
  input  wire logic                         wr_valid,
  input  wire logic [pad_pkg::WORD_W-1:0]   wr_data,
  input  wire logic                         stall,
  input  wire logic                         slow,
  output logic                              wr_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [pad_pkg::WORD_W-1:0] got[$];
  logic                       tog = 1'h0;
  initial wr_ready = 1'h0;
  always @(posedge sys_clk) begin
    if (wr_valid === 1'h1 && wr_ready) begin
      got.push_back(wr_data);
    end
    #1;
    tog = ~tog;
    wr_ready = !stall && (!slow || tog);
  end
endmodule : pad_buf_sink
`default_nettype wire
